// ---- ext_lines.sv ----
`timescale 1ns/100ps
// Far-side equipment on the lines; where the card does not drive, its level toggles
// every cycle so that a released pin never reads as a stable value.
module ext_lines (
  input wire logic mclk_i, // Clock.
  input wire logic [3:0] drive_i, // Card drive value.
  input wire logic [3:0] enable_i, // Card output enable.
  output logic [3:0] level_o // Resolved pin levels.
);
  logic [3:0] far_reg = 4'h5;
  // Own level of the equipment.
  always_ff @(posedge mclk_i) begin
    far_reg <= ~far_reg;
  end
  // The card wins wherever its enable is high.
  assign level_o = (enable_i & drive_i) | (~enable_i & far_reg);
endmodule // ext_lines

// ---- pgen_chk_assertions.sv ----
`timescale 1ns/100ps
`include "pgen_regs.svh"
// Watches the register port and the line drivers of the routing top.
module pgen_chk #(
  parameter int NUM_LINES = 4, // Lines fitted on the card.
  parameter logic [31:0] AVAIL_MODES = 32'h00080000 // Offered line modes.
) (
  input wire logic mclk_i, // Clock.
  input wire logic srst_i, // Reset.
  input wire logic reg_wr_i, // Write strobe.
  input wire logic reg_rd_i, // Read strobe.
  input wire logic [19:0] reg_idx_i, // Register index.
  input wire logic [31:0] reg_wdata_i, // Write data.
  input wire logic [31:0] reg_rdata_o, // Read data.
  input wire logic reg_rvalid_o, // Read valid.
  input wire logic card_start_i, // Start command.
  input wire logic apply_setup_i, // Write-setup command.
  input wire logic [3:0] line_oe_o // Line enables.
);
  logic [3:0] cfg1_reg;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // Shadow of unit 1 flags; only unit 1 is shadowed to keep the checker small.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cfg1_reg <= 4'h0;
    end else if (reg_wr_i && reg_idx_i == `UNIT1_TRIG_CFG_IDX) begin
      cfg1_reg <= reg_wdata_i[3:0];
    end
  end
  a_read_answered: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  a_valid_caused: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("read valid without read");
  a_rdata_quiet: assert property (!reg_rvalid_o |-> reg_rdata_o == 32'h0)
    else $error("read data not zero when idle");
  a_avail_mask_value: assert property (reg_rd_i && reg_idx_i == `LINE0_MODES_AVAIL_IDX
    |=> reg_rdata_o == AVAIL_MODES) else $error("available modes wrong");
  a_cfg_own_reg: assert property (reg_rd_i && !reg_wr_i && reg_idx_i == `UNIT1_TRIG_CFG_IDX
    |=> reg_rdata_o == {28'h0, cfg1_reg}) else $error("unit config readback wrong");
  a_oe_at_setup: assert property ($changed(line_oe_o) |-> $past(apply_setup_i) ||
    $past(card_start_i) || $past(apply_setup_i, 2) || $past(card_start_i, 2))
    else $error("line enable changed without setup");
  a_reset_tristate: assert property ($fell(srst_i) |-> line_oe_o == 4'h0)
    else $error("line driven after reset");
  a_no_fourth_line: assert property (NUM_LINES < 4 |-> line_oe_o[3] == 1'b0)
    else $error("absent line driven");
endmodule // pgen_chk

// ---- pgen_input_sync.sv ----
`timescale 1ns/100ps
// Two-stage synchroniser for a bus of asynchronous levels.
module pgen_input_sync #(
  parameter int WIDTH = 4
) (
  input wire logic mclk_i, // System clock.
  input wire logic srst_i, // Synchronous reset.
  input wire logic [WIDTH-1:0] async_i, // Asynchronous levels.
  output logic [WIDTH-1:0] sync_o // Synchronised levels.
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule // pgen_input_sync

// ---- pgen_pkg.sv ----
package pgen_pkg;
  typedef enum logic [1:0] {PH_IDLE, PH_RUN, PH_DONE} unit_phase_t;
  typedef enum logic [1:0] {TM_TRIGGERED, TM_GATED, TM_SINGLE} trig_mode_t;
  typedef enum logic [1:0] {S1_UNUSED, S1_RUN, S1_ARM} sel1_src_t;
endpackage

// ---- pgen_regs.svh ----
`ifndef PGEN_REGS_SVH
`define PGEN_REGS_SVH
// Register indices decoded on the register port.
`define LINE0_MODE_SELECT_IDX 20'h92888
`define LINE1_MODE_SELECT_IDX 20'h92889
`define LINE2_MODE_SELECT_IDX 20'h9288A
`define LINE3_MODE_SELECT_IDX 20'h9288B
`define LINE0_MODES_AVAIL_IDX 20'h928EC
`define LINE1_MODES_AVAIL_IDX 20'h928ED
`define LINE2_MODES_AVAIL_IDX 20'h928EE
`define LINE3_MODES_AVAIL_IDX 20'h928EF
`define UNIT0_TRIG_CFG_IDX 20'h92BAF
`define UNIT1_TRIG_CFG_IDX 20'h92C13
`define UNIT2_TRIG_CFG_IDX 20'h92C77
`define UNIT3_TRIG_CFG_IDX 20'h92CDB
`define UNIT_ENABLE_MASK_IDX 20'h92D3F
`define UNIT_COMMAND_PORT_IDX 20'h92D40
`define UNIT_PERIOD_IDX_BASE 20'h92D50
`define UNIT_HIGH_IDX_BASE 20'h92D54
`define UNIT_LOOPS_IDX_BASE 20'h92D58
`define UNIT_SEL_IDX_BASE 20'h92D5C
// Configuration bit positions.
`define CFG_FIRST_INV_BIT 0
`define CFG_SECOND_INV_BIT 1
`define CFG_OUT_INV_BIT 2
`define CFG_LEVEL_BIT 3
// Line mode and command codes.
`define LINE_TRISTATE_MODE 32'h00000000
`define LINE_PULSE_OUTPUT_MODE 32'h00080000
`define SOFTWARE_FORCE_COMMAND 32'h00000001
// Reset values.
`define CFG_RESET 4'h0
`define MODE_RESET 32'h00000000
`endif

// ---- pgen_routing_top.sv ----
`timescale 1ns/100ps
`include "pgen_regs.svh"
// Operation
// [R1] Generation stage trigger input always high-active.
// [R2] First-selector invert flag inverts first selector.
// [R3] Second-selector invert flag inverts second selector.
// [R4] Output invert flag inverts unit pulses.
// [R5] Rising edge default; level flag detects high.
// [R6] Any flag combination is honoured.
// [R7] Each unit has its own config register.
// [R8] Pulse mode drives line from same unit.
// [R9] Disable mode, reset default, leaves line tristate.
// [R10] Exactly one mode active per line.
// [R11] Read-only available-modes mask per line.
// [R12] Three-line cards: fourth unit cascade only.
// [R13] Line modes apply at start or write-setup.
// [R14] Enable bit arms unit trigger detection.
// [R15] Loop count zero repeats endlessly.
// [R16] Force starts all software-triggered units together.
// [R17] Enable zero plus write-setup halts output.
// [R18] Period and high count generator clocks.
// [R19] Unused selector outputs static high.
// [R20] Force is one rising edge to all.
// [R21] Triggered mode ignores trigger until done.
// [R22] Gate low stops and resets counters.
// [R23] Selector inverters precede edge/level detector.
module pgen_routing_top
  import pgen_pkg::*;
#(
  parameter int NUM_LINES = 4, // Three on smaller cards.
  parameter logic [31:0] AVAIL_MODES = 32'h00080000
) (
  input wire logic mclk_i, // Pulse generator clock.
  input wire logic srst_i, // Synchronous reset.
  input wire logic reg_wr_i, // Register write strobe.
  input wire logic reg_rd_i, // Register read strobe.
  input wire logic [19:0] reg_idx_i, // Register index.
  input wire logic [31:0] reg_wdata_i, // Write data.
  output logic [31:0] reg_rdata_o, // Read data.
  output logic reg_rvalid_o, // Read data valid pulse.
  input wire logic card_start_i, // Card start command pulse.
  input wire logic apply_setup_i, // Write-setup command pulse.
  input wire logic run_state_i, // Card running level.
  input wire logic arm_state_i, // Card armed level.
  input wire logic card_trigger_i, // Card trigger output level.
  input wire logic [3:0] line_in_i, // Multi-purpose line pin levels.
  output logic [3:0] line_out_o, // Multi-purpose line drive value.
  output logic [3:0] line_oe_o // Multi-purpose line output enable.
);
  typedef struct packed {
    logic [3:0][31:0] mode_pend;
    logic [3:0][31:0] mode_act;
    logic [3:0][3:0] cfg;
    logic [3:0] en_pend;
    logic [3:0] en_act;
    logic [3:0][31:0] period;
    logic [3:0][31:0] high;
    logic [3:0][31:0] loops;
    logic [3:0][7:0] sel;
    logic force_pulse;
    logic [31:0] rdata;
    logic rvalid;
    logic [3:0] lout;
    logic [3:0] loe;
  } top_state_t;

  top_state_t st_reg;
  top_state_t st_next;
  logic [3:0] line_sync;
  logic [3:0] pulse;
  logic [3:0] sel1;
  logic [3:0] sel2;
  logic [3:0][19:0] cfg_idx;
  logic [3:0][19:0] mode_idx;
  logic [3:0][19:0] avail_idx;

  assign cfg_idx = {20'(`UNIT3_TRIG_CFG_IDX), 20'(`UNIT2_TRIG_CFG_IDX),
                    20'(`UNIT1_TRIG_CFG_IDX), 20'(`UNIT0_TRIG_CFG_IDX)};
  assign mode_idx = {20'(`LINE3_MODE_SELECT_IDX), 20'(`LINE2_MODE_SELECT_IDX),
                     20'(`LINE1_MODE_SELECT_IDX), 20'(`LINE0_MODE_SELECT_IDX)};
  assign avail_idx = {20'(`LINE3_MODES_AVAIL_IDX), 20'(`LINE2_MODES_AVAIL_IDX),
                      20'(`LINE1_MODES_AVAIL_IDX), 20'(`LINE0_MODES_AVAIL_IDX)};

  // Pin inputs cross into the clock domain before any selector sees them.
  pgen_input_sync #(.WIDTH(4)) u_sync (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .async_i(line_in_i),
    .sync_o(line_sync)
  );

  // Selector muxes; sel byte: [1:0] first source, [7:4] second source.
  always_comb begin
    for (int u = 0; u < 4; u++) begin
      unique case (st_reg.sel[u][1:0])
        2'h1: sel1[u] = run_state_i;
        2'h2: sel1[u] = arm_state_i;
        default: sel1[u] = 1'b1; // [R19]
      endcase
      unique case (st_reg.sel[u][7:4])
        4'h1: sel2[u] = st_reg.force_pulse; // [R16] [R20]
        4'h2: sel2[u] = card_trigger_i;
        4'h3: sel2[u] = (u != 0) ? pulse[0] : 1'b1;
        4'h4: sel2[u] = (u != 1) ? pulse[1] : 1'b1;
        4'h5: sel2[u] = (u != 2) ? pulse[2] : 1'b1;
        4'h6: sel2[u] = (u != 3) ? pulse[3] : 1'b1; // [R12]
        4'h7: sel2[u] = line_sync[0];
        4'h8: sel2[u] = line_sync[1];
        4'h9: sel2[u] = line_sync[2];
        4'hA: sel2[u] = line_sync[3];
        default: sel2[u] = 1'b1; // [R19]
      endcase
    end
  end

  // One generator per unit, fed from the written settings and the active enable.
  for (genvar g = 0; g < 4; g++) begin : g_unit
    pgen_unit u_unit (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .enable_i(st_reg.en_act[g]), // [R14]
      .cfg_i(st_reg.cfg[g]), // [R7]
      .mode_i(trig_mode_t'(st_reg.sel[g][3:2])),
      .sel1_i(sel1[g]),
      .sel2_i(sel2[g]),
      .period_i(st_reg.period[g]),
      .high_i(st_reg.high[g]),
      .loops_i(st_reg.loops[g]),
      .pulse_o(pulse[g])
    );
  end

  // Register writes, reads, command handling and line drive.
  always_comb begin
    st_next = st_reg;
    st_next.force_pulse = 1'b0;
    st_next.rvalid = reg_rd_i;
    st_next.rdata = 32'h00000000;
    for (int u = 0; u < 4; u++) begin
      if (reg_wr_i && reg_idx_i == cfg_idx[u]) begin
        st_next.cfg[u] = reg_wdata_i[3:0]; // [R6] [R7]
      end
      if (reg_wr_i && reg_idx_i == mode_idx[u]) begin
        st_next.mode_pend[u] = reg_wdata_i; // [R13]
      end
      if (reg_wr_i && reg_idx_i == `UNIT_PERIOD_IDX_BASE + 20'(u)) begin
        st_next.period[u] = reg_wdata_i;
      end
      if (reg_wr_i && reg_idx_i == `UNIT_HIGH_IDX_BASE + 20'(u)) begin
        st_next.high[u] = reg_wdata_i;
      end
      if (reg_wr_i && reg_idx_i == `UNIT_LOOPS_IDX_BASE + 20'(u)) begin
        st_next.loops[u] = reg_wdata_i;
      end
      if (reg_wr_i && reg_idx_i == `UNIT_SEL_IDX_BASE + 20'(u)) begin
        st_next.sel[u] = reg_wdata_i[7:0];
      end
      if (reg_rd_i && reg_idx_i == cfg_idx[u]) begin
        st_next.rdata = {28'h0000000, st_reg.cfg[u]};
      end
      if (reg_rd_i && reg_idx_i == mode_idx[u]) begin
        st_next.rdata = st_reg.mode_pend[u];
      end
      if (reg_rd_i && reg_idx_i == avail_idx[u]) begin
        st_next.rdata = (u < NUM_LINES) ? AVAIL_MODES : 32'h00000000; // [R11] [R12]
      end
    end
    if (reg_wr_i && reg_idx_i == `UNIT_ENABLE_MASK_IDX) begin
      st_next.en_pend = reg_wdata_i[3:0];
    end
    if (reg_rd_i && reg_idx_i == `UNIT_ENABLE_MASK_IDX) begin
      st_next.rdata = {28'h0000000, st_reg.en_act};
    end
    // The force command is a single cycle high, seen by all units at once.
    if (reg_wr_i && reg_idx_i == `UNIT_COMMAND_PORT_IDX &&
        reg_wdata_i == `SOFTWARE_FORCE_COMMAND) begin
      st_next.force_pulse = 1'b1; // [R16] [R20]
    end
    // Pending modes and enables only take hold on start or write-setup.
    if (card_start_i || apply_setup_i) begin
      st_next.mode_act = st_next.mode_pend; // [R13]
      st_next.en_act = st_next.en_pend; // [R17]
    end
    // Only the exact pulse code drives; any other value keeps the line off.
    for (int l = 0; l < 4; l++) begin
      st_next.lout[l] = 1'b0;
      st_next.loe[l] = 1'b0; // [R9]
      if (l < NUM_LINES && st_reg.mode_act[l] == `LINE_PULSE_OUTPUT_MODE) begin // [R10] [R12]
        st_next.lout[l] = pulse[l]; // [R8]
        st_next.loe[l] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_reg <= '0; // Modes reset to tristate, units disabled. [R9]
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o = st_reg.rdata;
  assign reg_rvalid_o = st_reg.rvalid;
  assign line_out_o = st_reg.lout;
  assign line_oe_o = st_reg.loe;
endmodule // pgen_routing_top

// ---- pgen_unit.sv ----
`timescale 1ns/100ps
`include "pgen_regs.svh"
// One pulse generator: trigger conditioning and period/high/loop counting.
module pgen_unit
  import pgen_pkg::*;
(
  input wire logic mclk_i, // Pulse generator clock.
  input wire logic srst_i, // Synchronous reset.
  input wire logic enable_i, // Unit armed.
  input wire logic [3:0] cfg_i, // Invert and level flags.
  input wire trig_mode_t mode_i, // Trigger mode.
  input wire logic sel1_i, // First selector output.
  input wire logic sel2_i, // Second selector output.
  input wire logic [31:0] period_i, // Period length in cycles.
  input wire logic [31:0] high_i, // High time in cycles.
  input wire logic [31:0] loops_i, // Loop count, zero endless.
  output logic pulse_o // Pulse stream after output inverter.
);
  typedef struct packed {
    unit_phase_t phase;
    logic trig_prev;
    logic [31:0] cnt;
    logic [31:0] loops;
    logic pulse;
  } unit_state_t;

  unit_state_t st_reg;
  unit_state_t st_next;
  logic trig;
  logic fire;

  // Inverters sit before the detector, so the stage input stays high-active.
  assign trig = (sel1_i ^ cfg_i[`CFG_FIRST_INV_BIT]) & (sel2_i ^ cfg_i[`CFG_SECOND_INV_BIT]); // [R1] [R2] [R3] [R19] [R23]
  assign fire = cfg_i[`CFG_LEVEL_BIT] ? trig : (trig & ~st_reg.trig_prev); // [R5] [R6]

  // Period and high counter; a truncated high time gives a shorter high phase.
  always_comb begin
    st_next = st_reg;
    st_next.trig_prev = trig;
    unique case (st_reg.phase)
      PH_IDLE: begin
        st_next.pulse = 1'b0;
        if (enable_i && fire) begin // [R14]
          st_next.phase = PH_RUN;
          st_next.cnt = 32'h00000000;
          st_next.loops = 32'h00000000;
        end
      end
      PH_RUN: begin
        st_next.pulse = (st_reg.cnt < high_i); // [R18]
        if (st_reg.cnt + 32'h00000001 >= period_i) begin
          st_next.cnt = 32'h00000000;
          st_next.loops = st_reg.loops + 32'h00000001;
          if (loops_i != 32'h00000000 && st_reg.loops + 32'h00000001 >= loops_i) begin // [R15]
            // Triggered rearms, single shot waits for re-enable.
            st_next.phase = (mode_i == TM_SINGLE) ? PH_DONE : PH_IDLE; // [R21]
          end
        end else begin
          st_next.cnt = st_reg.cnt + 32'h00000001;
        end
        // A falling gate stops output and clears every counter.
        if (mode_i == TM_GATED && !trig) begin // [R22]
          st_next.phase = PH_IDLE;
          st_next.cnt = 32'h00000000;
          st_next.loops = 32'h00000000;
          st_next.pulse = 1'b0;
        end
      end
      PH_DONE: begin
        st_next.pulse = 1'b0;
      end
      default: st_next.phase = PH_IDLE;
    endcase
    // Disabling halts output at once.
    if (!enable_i) begin // [R17]
      st_next.phase = PH_IDLE;
      st_next.pulse = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_reg <= '{phase: PH_IDLE, trig_prev: 1'b1, cnt: '0, loops: '0, pulse: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pulse_o = st_reg.pulse ^ cfg_i[`CFG_OUT_INV_BIT]; // [R4]
endmodule // pgen_unit

// ---- tb_top.sv ----
`timescale 1ns/100ps
`include "pgen_regs.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  logic mclk_i, srst_i, reg_wr_i, reg_rd_i, card_start_i, apply_setup_i, reg_rvalid_o;
  logic [19:0] reg_idx_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [3:0] line_in_i, line_out_o, line_oe_o;
  logic trig_lvl;
  logic [3:0] line_oe3;
  int failures = 0;
  int checks_done = 0;
  localparam logic [19:0] CI [4] = '{`UNIT0_TRIG_CFG_IDX, `UNIT1_TRIG_CFG_IDX,
    `UNIT2_TRIG_CFG_IDX, `UNIT3_TRIG_CFG_IDX};
  pgen_routing_top uut (.mclk_i(mclk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_idx_i(reg_idx_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .card_start_i(card_start_i),
    .apply_setup_i(apply_setup_i), .run_state_i(1'b0), .arm_state_i(1'b0),
    .card_trigger_i(trig_lvl), .line_in_i(line_in_i), .line_out_o(line_out_o),
    .line_oe_o(line_oe_o));
  // A three-line card on the same bus; its fourth unit must never reach a pin.
  pgen_routing_top #(.NUM_LINES(3)) uut3 (.mclk_i(mclk_i), .srst_i(srst_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_idx_i(reg_idx_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(), .reg_rvalid_o(),
    .card_start_i(card_start_i), .apply_setup_i(apply_setup_i), .run_state_i(1'b0),
    .arm_state_i(1'b0), .card_trigger_i(trig_lvl), .line_in_i(line_in_i),
    .line_out_o(), .line_oe_o(line_oe3));
  ext_lines far (.mclk_i(mclk_i), .drive_i(line_out_o), .enable_i(line_oe_o),
    .level_o(line_in_i));
  // Expected count of high cycles over a number of whole periods.
  function automatic int ones(input int h, input int k);
    return h * k;
  endfunction
  task automatic wr(input logic [19:0] i, input logic [31:0] d);
    @(posedge mclk_i);
    reg_idx_i <= i;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] i, output logic [31:0] d);
    @(posedge mclk_i);
    reg_idx_i <= i;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
    `CHK("rvalid", 1'b1, reg_rvalid_o)
  endtask
  // Command pulses last one cycle, as the setup port expects.
  task automatic cmd(input logic start);
    @(posedge mclk_i);
    card_start_i <= start;
    apply_setup_i <= !start;
    @(posedge mclk_i);
    card_start_i <= 1'b0;
    apply_setup_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    #1;
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Clock at 200 MHz.
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  // Watchdog, far beyond the few hundred cycles the tests need.
  initial begin
    #200000;
    failures++;
    stop_test();
  end
  // Main sequence.
  initial begin
    logic [31:0] d;
    logic [3:0] c [4];
    int per, hi, n, n3, t;
    {srst_i, reg_wr_i, reg_rd_i, card_start_i, apply_setup_i} = 5'h10;
    reg_idx_i = 20'h0;
    reg_wdata_i = 32'h0;
    trig_lvl = 1'b0;
    d = $urandom(80);
    repeat (2) @(posedge mclk_i);
    srst_i <= 1'b0;
    for (int u = 0; u < 4; u++) begin
      rd(`LINE0_MODE_SELECT_IDX + 20'(u), d);
      `CHK("mode reset", `MODE_RESET, d)
    end
    wr(`LINE0_MODES_AVAIL_IDX, 32'h0);
    rd(`LINE0_MODES_AVAIL_IDX, d);
    `CHK("avail", 32'h00080000, d)
    rd(20'h00001, d);
    `CHK("unmapped", 32'h0, d)
    `CHK("oe reset", 4'h0, line_oe_o)
    $display("test reset done");
    for (int u = 0; u < 4; u++) begin
      c[u] = (u == 3) ? 4'hF : 4'($urandom());
      wr(CI[u], {28'h0, c[u]});
    end
    for (int u = 0; u < 4; u++) begin
      rd(CI[u], d);
      `CHK("cfg", {28'h0, c[u]}, d)
    end
    $display("test config done");
    per = 4 + $urandom() % 4;
    hi = 1 + $urandom() % 3;
    for (int u = 0; u < 4; u++) begin
      wr(`UNIT_PERIOD_IDX_BASE + 20'(u), per);
      wr(`UNIT_HIGH_IDX_BASE + 20'(u), hi);
      wr(`UNIT_LOOPS_IDX_BASE + 20'(u), 32'h0);
      wr(`UNIT_SEL_IDX_BASE + 20'(u), (u == 3) ? 32'h00 : 32'h10);
      wr(`LINE0_MODE_SELECT_IDX + 20'(u), `LINE_PULSE_OUTPUT_MODE);
      wr(CI[u], (u == 1) ? 32'h4 : (u == 3) ? 32'h8 : 32'h0);
    end
    wr(`UNIT_ENABLE_MASK_IDX, 32'hB);
    repeat (4) @(posedge mclk_i);
    #1;
    `CHK("oe pending", 4'h0, line_oe_o)
    cmd(1'b0);
    `CHK("oe active", 4'hF, line_oe_o)
    `CHK("three lines", 4'h7, line_oe3)
    `CHK("idle inverted", 2'b10, line_out_o[1:0])
    wr(`UNIT_COMMAND_PORT_IDX, `SOFTWARE_FORCE_COMMAND);
    t = 0;
    while (line_out_o[0] !== 1'b1 && t < 50) begin
      @(posedge mclk_i);
      #1;
      t++;
    end
    n = 0;
    n3 = 0;
    for (int k = 0; k < 3 * per; k++) begin
      n += line_out_o[0];
      n3 += line_out_o[3];
      `CHK("common start", ~line_out_o[0], line_out_o[1])
      `CHK("disabled unit", 1'b0, line_out_o[2])
      @(posedge mclk_i);
      #1;
    end
    `CHK("high cycles", ones(hi, 3), n)
    `CHK("level trigger", 1'b1, n3 > 0)
    $display("test pulses done");
    wr(`UNIT_ENABLE_MASK_IDX, 32'h0);
    cmd(1'b0);
    for (int k = 0; k < 2 * per; k++) begin
      `CHK("halted", 2'b10, line_out_o[1:0])
      @(posedge mclk_i);
      #1;
    end
    // Inverted low selectors become level triggers: unit 2 single shot, unit 3 gated.
    wr(`UNIT_LOOPS_IDX_BASE + 20'(2), 32'h1);
    wr(`UNIT_SEL_IDX_BASE + 20'(2), 32'h09);
    wr(CI[2], 32'h9);
    wr(`UNIT_SEL_IDX_BASE + 20'(3), 32'h24);
    wr(CI[3], 32'hA);
    wr(`UNIT_ENABLE_MASK_IDX, 32'hC);
    cmd(1'b0);
    n = 0;
    n3 = 0;
    for (int k = 0; k < 3 * per; k++) begin
      n += line_out_o[2];
      n3 += line_out_o[3];
      @(posedge mclk_i);
      #1;
    end
    `CHK("single shot", ones(hi, 1), n)
    `CHK("gate open", 1'b1, n3 > 0)
    @(posedge mclk_i);
    trig_lvl <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
    for (int k = 0; k < 2 * per; k++) begin
      `CHK("gate closed", 1'b0, line_out_o[3])
      @(posedge mclk_i);
      #1;
    end
    $display("test modes done");
    wr(`LINE0_MODE_SELECT_IDX, `LINE_TRISTATE_MODE);
    cmd(1'b1);
    `CHK("oe tristate", 4'hE, line_oe_o)
    $display("test stop done");
    stop_test();
  end
endmodule // tb_top
bind pgen_routing_top pgen_chk #(.NUM_LINES(NUM_LINES), .AVAIL_MODES(AVAIL_MODES)) chk (
  .mclk_i(mclk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_idx_i(reg_idx_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .card_start_i(card_start_i),
  .apply_setup_i(apply_setup_i), .line_oe_o(line_oe_o));
